// File: dv/irq_line_host.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================
// Host side of the interrupt line with its pull-up
module irq_line_host (
    input wire logic irq_n_out, // Device pin drive value
    input wire logic irq_n_oe,  // Device pulls the pin
    output logic irq_pin        // Resolved pin level
);
    // Pull-up wins whenever the device lets go
    assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;
endmodule : irq_line_host
`default_nettype wire

// File: dv/light_proximity_channel_sensor_ctrl_status_test.sv
`timescale 1ns/1ns
`default_nettype none
module light_proximity_channel_sensor_ctrl_status_test;
    import lps_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic amb_sample_vld = 1'b0;
    logic [13:0] amb_reading = 14'h0000;
    logic amb_overflow = 1'b0;
    logic [13:0] amb_upper = 14'h1000;
    logic [13:0] amb_lower = 14'h0100;
    logic proximity_channel_sample_vld = 1'b0;
    logic [7:0] proximity_channel_reading = 8'h00;
    logic amb_run, proximity_channel_run, irq_n_out, irq_n_oe, irq_pin;
    logic [1:0] amb_channel_sel;
    logic [8:0] green_gain, infrared_gain;
    logic rd_seen = 1'b0;
    logic rev1_oe;
    logic [7:0] exp_q[$];
    int failures = 0;
    int compares = 0;
    int seed = 32'h51b8_e085;
    logic [7:0] ofs[7] = '{8'h01, 8'h0A, 8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h20};
    logic [7:0] rst_val[7] = '{8'h24, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
    // =====================================
    // Clock and instances
    always #2 core_clk = ~core_clk;
    light_proximity_channel_sensor_ctrl_status dut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .amb_sample_vld(amb_sample_vld), .amb_reading(amb_reading), .amb_overflow(amb_overflow),
        .amb_upper(amb_upper), .amb_lower(amb_lower), .proximity_channel_sample_vld(proximity_channel_sample_vld),
        .proximity_channel_reading(proximity_channel_reading), .amb_run(amb_run), .proximity_channel_run(proximity_channel_run),
        .amb_channel_sel(amb_channel_sel), .green_gain(green_gain), .infrared_gain(infrared_gain),
        .irq_n_in(irq_pin), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
    );
    irq_line_host host (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_pin(irq_pin));
    // First revision copy, watched only for its pull-down
    light_proximity_channel_sensor_ctrl_status #(.FIRST_REV(1'b1)) rev1 (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(),
        .amb_sample_vld(amb_sample_vld), .amb_reading(amb_reading), .amb_overflow(amb_overflow),
        .amb_upper(amb_upper), .amb_lower(amb_lower), .proximity_channel_sample_vld(proximity_channel_sample_vld),
        .proximity_channel_reading(proximity_channel_reading), .amb_run(), .proximity_channel_run(),
        .amb_channel_sel(), .green_gain(), .infrared_gain(),
        .irq_n_in(irq_pin), .irq_n_out(), .irq_n_oe(rev1_oe)
    );
    // =====================================
    // Comparison and closing
    task check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task test_done;
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    // =====================================
    // Read data monitor, one note taken per answered read
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                check(9'h1FF, {1'b0, reg_rdata});
            end else begin
                check({1'b0, reg_rdata}, {1'b0, exp_q.pop_front()});
            end
        end
    end
    // =====================================
    // Bus and sample drivers
    task cyc;
        @(posedge core_clk);
        #1;
    endtask : cyc
    task wr(input logic [7:0] a, input logic [7:0] d);
        cyc;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cyc;
        reg_wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        cyc;
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        cyc;
        reg_rd = 1'b0;
    endtask : rd
    task pin(input logic e);
        cyc;
        cyc;
        check({8'h00, irq_pin}, {8'h00, e});
    endtask : pin
    task amb_smp(input logic out, input logic ovf);
        cyc;
        amb_sample_vld = 1'b1;
        amb_overflow = ovf;
        if (out) begin
            amb_reading = 14'h1001 + (14'($random(seed)) & 14'h0FFF);
        end else begin
            amb_reading = 14'h0101 + (14'($random(seed)) & 14'h07FF);
        end
        cyc;
        amb_sample_vld = 1'b0;
        amb_overflow = 1'b0;
    endtask : amb_smp
    task proximity_channel_smp(input logic [7:0] r);
        cyc;
        proximity_channel_sample_vld = 1'b1;
        proximity_channel_reading = r;
        cyc;
        proximity_channel_sample_vld = 1'b0;
    endtask : proximity_channel_smp
    function automatic logic [7:0] above();
        return 8'h41 + (8'($random(seed)) % 8'hBF);
    endfunction : above
    // =====================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done;
    end
    // =====================================
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        pin(1'b0);
        check({8'h00, rev1_oe}, 9'h000);
        check(green_gain, 9'h080);
        check(infrared_gain, 9'h100);
        wr(8'h01, 8'h24);
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], rst_val[i]);
        end
        rd(8'h00, 8'h04);
        rd(8'h00, 8'h00);
        pin(1'b1);
        // Masked and read-only writes
        wr(8'h01, 8'hC7);
        rd(8'h01, 8'h07);
        wr(8'h0A, 8'hFF);
        rd(8'h0A, 8'h0F);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        // Host fine gains, then factory gains
        wr(8'h0F, 8'hA5);
        wr(8'h10, 8'h3C);
        pin(1'b1);
        check(green_gain, 9'h0A4);
        check(infrared_gain, 9'h079);
        wr(8'h01, 8'h27);
        pin(1'b1);
        check(green_gain, 9'h080);
        check(infrared_gain, 9'h100);
        // Each legal mode; reserved codes are never written
        for (int m = 0; m < 6; m++) begin
            wr(8'h01, {3'b000, 3'(m), 2'b00});
            pin(1'b1);
            check({8'h00, amb_run}, {8'h00, m inside {[1:4]}});
            check({8'h00, proximity_channel_run}, {8'h00, m inside {4, 5}});
            if (m < 4) begin
                check({7'h00, amb_channel_sel}, 9'(m));
            end
        end
        wr(8'h01, 8'h00);
        rd(8'h0F, 8'hA5);
        rd(8'h0A, 8'h0F);
        // Proximity events
        wr(8'h0A, 8'h00);
        wr(8'h0C, 8'h40);
        wr(8'h01, 8'h16);
        proximity_channel_smp(8'h40);
        proximity_channel_smp(8'h40);
        proximity_channel_smp(above());
        rd(8'h00, 8'h00);
        proximity_channel_smp(above());
        pin(1'b0);
        check({8'h00, rev1_oe}, 9'h001);
        rd(8'h00, 8'h02);
        rd(8'h00, 8'h00);
        proximity_channel_smp(above());
        proximity_channel_smp(above());
        wr(8'h01, 8'h14);
        rd(8'h00, 8'h00);
        repeat (3) proximity_channel_smp(above());
        rd(8'h00, 8'h00);
        // Ambient window and overflow events
        wr(8'h0A, 8'h01);
        wr(8'h01, 8'h05);
        repeat (4) amb_smp(1'b1, 1'b0);
        rd(8'h00, 8'h00);
        amb_smp(1'b0, 1'b0);
        repeat (4) amb_smp(1'b1, 1'b0);
        rd(8'h00, 8'h00);
        amb_smp(1'b1, 1'b0);
        rd(8'h00, 8'h01);
        amb_smp(1'b0, 1'b1);
        pin(1'b0);
        rd(8'h00, 8'h01);
        amb_smp(1'b0, 1'b1);
        wr(8'h01, 8'h04);
        rd(8'h00, 8'h00);
        amb_smp(1'b0, 1'b1);
        repeat (4) amb_smp(1'b1, 1'b0);
        rd(8'h00, 8'h00);
        pin(1'b1);
        test_done;
    end
endmodule : light_proximity_channel_sensor_ctrl_status_test
`default_nettype wire

// File: hw/light_proximity_channel_sensor_ctrl_status.sv
// Behaviour
// - Power-on flag sets after every power-on reset.
// - Power-up returns all threshold settings to their defaults.
// - Any set flag pulls the interrupt line low.
// - First silicon revision: power-on flag does not pull interrupt low.
// - Reading status clears all flags and releases interrupt line.
// - Interrupt line is open drain, only pulled low.
// - Ambient and proximity flags held zero while their enables are zero.
// - Ambient flag sets when reading stays outside window beyond persist count.
// - Ambient conversion overflow also sets the ambient flag.
// - Ambient flag sticks until status read or enable cleared.
// - Proximity flag sets above limit beyond persist count; sticks likewise.
// - Power-on flag sticky, cleared only by status read.
// - Gain source bit picks host fine gains or factory gains.
// - Mode 000 stops measurements, registers keep contents.
// - Modes 001-011 ambient only, selecting diff, green or infrared.
// - Mode 100 interleaves both; mode 101 proximity only.
// - Proximity enable zero stops proximity comparisons.
// - Overflow sets ambient flag only when ambient enable is one.
`timescale 1ns/1ns
`default_nettype none
`include "lps_defines.svh"
module light_proximity_channel_sensor_ctrl_status
    import lps_pkg::*;
#(
    parameter bit FIRST_REV = 1'b0,              // First silicon revision
    parameter logic [8:0] FACTORY_GREEN = 9'h080, // Arbitrary factory gain
    parameter logic [8:0] FACTORY_IR = 9'h100      // Arbitrary factory gain
) (
    input wire logic core_clk,           // Core clock
    input wire logic nrst,               // Async power-on reset, low
    input wire logic [7:0] reg_addr,     // Register address from serial slave
    input wire logic reg_wr,             // Write strobe
    input wire logic [7:0] reg_wdata,    // Write data
    input wire logic reg_rd,             // Read strobe
    output logic [7:0] reg_rdata,        // Read data, valid cycle after strobe
    input wire logic amb_sample_vld,     // Ambient reading strobe
    input wire logic [13:0] amb_reading, // Ambient reading
    input wire logic amb_overflow,       // Ambient conversion overflow
    input wire logic [13:0] amb_upper,   // Ambient upper limit
    input wire logic [13:0] amb_lower,   // Ambient lower limit
    input wire logic proximity_channel_sample_vld,    // Proximity reading strobe
    input wire logic [7:0] proximity_channel_reading, // Proximity reading
    output logic amb_run,                // Ambient measurement enabled
    output logic proximity_channel_run,               // Proximity measurement enabled
    output logic [1:0] amb_channel_sel,  // 1 diff, 2 green, 3 infrared
    output logic [8:0] green_gain,       // Effective green gain
    output logic [8:0] infrared_gain,    // Effective infrared gain
    input wire logic irq_n_in,           // Interrupt pin level
    output logic irq_n_out,              // Interrupt pin output, always 0
    output logic irq_n_oe                // Interrupt pin pull-down enable
);
    // =====================================
    // Register storage
    logic power_on_flag_r;
    logic ambient_irq_flag_r;
    logic proximity_channel_irq_flag_r;
    reg_byte_t main_control_r;
    reg_byte_t persist_counts_r;
    reg_byte_t proximity_channel_above_indicator_r;
    reg_byte_t proximity_channel_level_limit_r;
    reg_byte_t green_fine_gain_r;
    reg_byte_t infrared_fine_gain_high_r;
    logic [1:0] irq_pin_sync_r;
    op_mode_e op_mode;
    logic ambient_irq_enable;
    logic proximity_channel_irq_enable;
    logic status_rd;
    logic amb_out;
    logic proximity_channel_above;
    logic amb_fire;
    logic proximity_channel_fire;
    logic amb_active;
    logic proximity_channel_active;
    logic irq_req;
    logic [8:0] infrared_fine_gain_value;

    function automatic logic is_wr(input logic [7:0] a, input logic [7:0] ofs, input logic wr);
        is_wr = wr && (a == ofs);
    endfunction : is_wr

    assign op_mode = op_mode_e'(main_control_r[`BIT_MODE_HI:`BIT_MODE_LO]);
    assign ambient_irq_enable = main_control_r[`BIT_AMB_EN];
    assign proximity_channel_irq_enable = main_control_r[`BIT_PROXIMITY_CHANNEL_EN];
    assign status_rd = reg_rd && (reg_addr == `OFS_IRQ_FLAGS);

    // =====================================
    // Configuration registers; reset restores thresholds and settings
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            main_control_r <= `RST_MAIN_CONTROL;
            persist_counts_r <= `RST_PERSIST;
            proximity_channel_above_indicator_r <= `RST_PROXIMITY_CHANNEL_ABOVE;
            proximity_channel_level_limit_r <= `RST_PROXIMITY_CHANNEL_LIMIT;
            green_fine_gain_r <= `RST_GREEN_GAIN;
            infrared_fine_gain_high_r <= `RST_IR_GAIN_HIGH;
        end else begin
            // Registers keep contents in every mode
            if (is_wr(reg_addr, `OFS_MAIN_CONTROL, reg_wr)) begin
                main_control_r <= {2'b00, reg_wdata[5:0]};
            end
            if (is_wr(reg_addr, `OFS_PERSIST_COUNTS, reg_wr)) begin
                persist_counts_r <= {4'h0, reg_wdata[3:0]};
            end
            if (is_wr(reg_addr, `OFS_PROXIMITY_CHANNEL_ABOVE, reg_wr)) begin
                proximity_channel_above_indicator_r <= reg_wdata;
            end
            if (is_wr(reg_addr, `OFS_PROXIMITY_CHANNEL_LIMIT, reg_wr)) begin
                proximity_channel_level_limit_r <= reg_wdata;
            end
            if (is_wr(reg_addr, `OFS_GREEN_GAIN, reg_wr)) begin
                green_fine_gain_r <= reg_wdata;
            end
            if (is_wr(reg_addr, `OFS_IR_GAIN_HIGH, reg_wr)) begin
                infrared_fine_gain_high_r <= reg_wdata;
            end
        end
    end

    // =====================================
    // Measurement sequencing by mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            amb_run <= 1'b0;
            proximity_channel_run <= 1'b0;
            amb_channel_sel <= 2'h0;
        end else begin
            unique case (op_mode)
                MODE_AMB_DIFF, MODE_AMB_GREEN, MODE_AMB_IR: begin
                    amb_run <= 1'b1;
                    proximity_channel_run <= 1'b0;
                    amb_channel_sel <= main_control_r[3:2];
                end
                MODE_INTERLEAVE: begin
                    amb_run <= 1'b1;
                    proximity_channel_run <= 1'b1;
                    amb_channel_sel <= 2'h1;
                end
                MODE_PROXIMITY_CHANNEL_ONLY: begin
                    amb_run <= 1'b0;
                    proximity_channel_run <= 1'b1;
                    amb_channel_sel <= 2'h0;
                end
                default: begin
                    amb_run <= 1'b0;
                    proximity_channel_run <= 1'b0;
                    amb_channel_sel <= 2'h0;
                end
            endcase
        end
    end

    // =====================================
    // Gain source selection
    assign infrared_fine_gain_value = {infrared_fine_gain_high_r, green_fine_gain_r[0]};
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            green_gain <= 9'h000;
            infrared_gain <= 9'h000;
        end else if (main_control_r[`BIT_GAIN_SRC]) begin
            green_gain <= FACTORY_GREEN;
            infrared_gain <= FACTORY_IR;
        end else begin
            green_gain <= {1'b0, green_fine_gain_r[7:1], 1'b0};
            infrared_gain <= infrared_fine_gain_value;
        end
    end

    // =====================================
    // Threshold comparisons and persistence
    assign amb_active = ambient_irq_enable && amb_run;
    assign proximity_channel_active = proximity_channel_irq_enable && proximity_channel_run;
    assign amb_out = (amb_reading > amb_upper) || (amb_reading < amb_lower);
    assign proximity_channel_above = proximity_channel_reading > proximity_channel_level_limit_r;

    persist_filter #(.CNT_W(4)) u_amb_pst (
        .core_clk(core_clk),
        .nrst(nrst),
        .active(amb_active),
        .sample_vld(amb_sample_vld),
        .cond(amb_out),
        .pst_code(persist_counts_r[`BIT_AMB_PST_HI:`BIT_AMB_PST_LO]),
        .fire(amb_fire)
    );
    persist_filter #(.CNT_W(4)) u_prx_pst (
        .core_clk(core_clk),
        .nrst(nrst),
        .active(proximity_channel_active),
        .sample_vld(proximity_channel_sample_vld),
        .cond(proximity_channel_above),
        .pst_code(persist_counts_r[`BIT_PRX_PST_HI:`BIT_PRX_PST_LO]),
        .fire(proximity_channel_fire)
    );

    // =====================================
    // Sticky flags; a new event wins over a read clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            power_on_flag_r <= 1'b1;
        end else if (status_rd) begin
            power_on_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ambient_irq_flag_r <= 1'b0;
        end else if (!ambient_irq_enable) begin
            ambient_irq_flag_r <= 1'b0;
        end else if (amb_fire || (amb_sample_vld && amb_overflow && amb_run)) begin
            ambient_irq_flag_r <= 1'b1;
        end else if (status_rd) begin
            ambient_irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            proximity_channel_irq_flag_r <= 1'b0;
        end else if (!proximity_channel_irq_enable) begin
            proximity_channel_irq_flag_r <= 1'b0;
        end else if (proximity_channel_fire) begin
            proximity_channel_irq_flag_r <= 1'b1;
        end else if (status_rd) begin
            proximity_channel_irq_flag_r <= 1'b0;
        end
    end

    // =====================================
    // Interrupt pin, open drain
    assign irq_req = ambient_irq_flag_r || proximity_channel_irq_flag_r || (power_on_flag_r && !FIRST_REV);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_oe <= irq_req;
        end
    end
    // Pin drive value, only ever low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_n_out <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
        end
    end

    // Pin level synchroniser, not readable, observed only by pin_pulled_a
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_pin_sync_r <= 2'b11;
        end else begin
            irq_pin_sync_r <= {irq_pin_sync_r[0], irq_n_in};
        end
    end

    // =====================================
    // Read data, registered; unmapped reads return zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_IRQ_FLAGS: reg_rdata <= {5'h00, power_on_flag_r, proximity_channel_irq_flag_r, ambient_irq_flag_r};
                `OFS_MAIN_CONTROL: reg_rdata <= main_control_r;
                `OFS_PERSIST_COUNTS: reg_rdata <= persist_counts_r;
                `OFS_PROXIMITY_CHANNEL_ABOVE: reg_rdata <= proximity_channel_above_indicator_r;
                `OFS_PROXIMITY_CHANNEL_LIMIT: reg_rdata <= proximity_channel_level_limit_r;
                `OFS_GREEN_GAIN: reg_rdata <= green_fine_gain_r;
                `OFS_IR_GAIN_HIGH: reg_rdata <= infrared_fine_gain_high_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // =====================================
    // Checks
    sequence status_read_s;
        status_rd && ambient_irq_enable && !amb_fire && !(amb_sample_vld && amb_overflow);
    endsequence

    pwr_reset_set_a: assert property (@(posedge core_clk) $rose(nrst) |-> power_on_flag_r)
        else $error("power flag not set after reset");
    pwr_sticky_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(power_on_flag_r) |-> $past(status_rd))
        else $error("power flag cleared without status read");
    irq_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (ambient_irq_flag_r || proximity_channel_irq_flag_r) |=> irq_n_oe)
        else $error("interrupt not driven");
    irq_rev_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (!ambient_irq_flag_r && !proximity_channel_irq_flag_r) |=> (irq_n_oe == ($past(power_on_flag_r) && !FIRST_REV)))
        else $error("power flag drive wrong for revision");
    read_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        status_read_s |=> !ambient_irq_flag_r)
        else $error("ambient flag survives status read");
    od_low_a: assert property (@(posedge core_clk) irq_n_out == 1'b0)
        else $error("interrupt pin drives high");
    enable_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !proximity_channel_irq_enable ##1 !proximity_channel_irq_enable |-> !proximity_channel_irq_flag_r)
        else $error("proximity_channel flag set while disabled");
    ovf_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (amb_sample_vld && amb_overflow && amb_run && ambient_irq_enable) ##1 ambient_irq_enable
        |-> ambient_irq_flag_r)
        else $error("overflow did not set ambient flag");
    gain_src_a: assert property (@(posedge core_clk) disable iff (!nrst)
        main_control_r[`BIT_GAIN_SRC] |=> infrared_gain == FACTORY_IR)
        else $error("factory gain not selected");
    shutdown_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (op_mode == MODE_SHUTDOWN) |=> !amb_run && !proximity_channel_run)
        else $error("measurement runs in shutdown");
    proximity_channel_only_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (op_mode == MODE_PROXIMITY_CHANNEL_ONLY) |=> proximity_channel_run && !amb_run)
        else $error("proximity_channel only mode wrong");
    pin_pulled_a: assert property (@(posedge core_clk) disable iff (!nrst)
        irq_n_oe ##1 irq_n_oe ##1 irq_n_oe |-> !irq_pin_sync_r[1])
        else $error("interrupt pin not low while pulled");
endmodule : light_proximity_channel_sensor_ctrl_status
`default_nettype wire

// File: hw/lps_defines.svh
`ifndef LPS_DEFINES_SVH
`define LPS_DEFINES_SVH
// =====================================
// Register offsets
`define OFS_IRQ_FLAGS 8'h00
`define OFS_MAIN_CONTROL 8'h01
`define OFS_PERSIST_COUNTS 8'h0A
`define OFS_PROXIMITY_CHANNEL_ABOVE 8'h0B
`define OFS_PROXIMITY_CHANNEL_LIMIT 8'h0C
`define OFS_GREEN_GAIN 8'h0F
`define OFS_IR_GAIN_HIGH 8'h10
// =====================================
// Reset values
`define RST_IRQ_FLAGS 8'h04
`define RST_MAIN_CONTROL 8'h24
`define RST_PERSIST 8'h00
`define RST_PROXIMITY_CHANNEL_ABOVE 8'h00
`define RST_PROXIMITY_CHANNEL_LIMIT 8'h00
`define RST_GREEN_GAIN 8'h80
`define RST_IR_GAIN_HIGH 8'h80
// =====================================
// Field positions
`define BIT_AMB_FLAG 0
`define BIT_PROXIMITY_CHANNEL_FLAG 1
`define BIT_PWR_FLAG 2
`define BIT_AMB_EN 0
`define BIT_PROXIMITY_CHANNEL_EN 1
`define BIT_MODE_LO 2
`define BIT_MODE_HI 4
`define BIT_GAIN_SRC 5
`define BIT_AMB_PST_LO 0
`define BIT_AMB_PST_HI 1
`define BIT_PRX_PST_LO 2
`define BIT_PRX_PST_HI 3
`endif

// File: hw/lps_pkg.sv
package lps_pkg;
    // Operating modes as held in the control register
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'h0,
        MODE_AMB_DIFF = 3'h1,
        MODE_AMB_GREEN = 3'h2,
        MODE_AMB_IR = 3'h3,
        MODE_INTERLEAVE = 3'h4,
        MODE_PROXIMITY_CHANNEL_ONLY = 3'h5,
        MODE_RSVD6 = 3'h6,
        MODE_RSVD7 = 3'h7
    } op_mode_e;
    typedef logic [7:0] reg_byte_t;
endpackage : lps_pkg

// File: hw/persist_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "lps_defines.svh"
// =====================================
// Persistence filter: fires after a condition holds for more than a count
module persist_filter #(
    parameter int CNT_W = 4
) (
    input wire logic core_clk,        // Core clock
    input wire logic nrst,            // Async reset, low
    input wire logic active,          // Comparison enabled
    input wire logic sample_vld,      // New reading strobe
    input wire logic cond,            // Reading outside limit
    input wire logic [1:0] pst_code,  // Persist count code
    output logic fire                 // One-cycle trigger
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit;

    // Count code 0..3 maps to 1,4,8,15 prior samples
    always_comb begin
        unique case (pst_code)
            2'h0: limit = CNT_W'(1);
            2'h1: limit = CNT_W'(4);
            2'h2: limit = CNT_W'(8);
            2'h3: limit = CNT_W'(15);
        endcase
    end

    // Consecutive out-of-limit counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (!active) begin
            cnt_r <= '0;
        end else if (sample_vld) begin
            if (!cond) begin
                cnt_r <= '0;
            end else if (cnt_r != limit) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    assign fire = active && sample_vld && cond && (cnt_r == limit);
endmodule : persist_filter
`default_nettype wire
